// ### logic/remappable_pin_crossbar.sv
// Function
// - Each remappable input has an 8-bit selector
// - Pin-range indices connect that numbered pin
// - Low indices select ground and internal sources
// - Six virtual pins 176-181 behave like pins
// - Virtual pin output loops to selecting inputs
// - Each pin has its own 7-bit output code
// - Code zero and reset leave default port
// - Serial peripheral output codes as tabled
// - CAN transmit and compare unit codes
// - Analog comparator output codes
// - Sync outputs and reference clock codes
// - PWM generator four to eight codes
// - Logic cell codes; cells three, four optional
// - No interlock between any mapping fields
// - Active remap overrides other digital pin functions
// - Analog function on pin keeps precedence
// - Input and output maps held separately
// - Safeguard blocks spurious mapping changes
// - Remappable input list covers listed peripherals
// - Input selectors reset to ground index
`timescale 1ns/100ps

module remappable_pin_crossbar #(
   parameter bit HAS_CELLS_34 = 1'b1
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic         in_wr,
   input  wire logic [5:0]   in_wr_idx,
   input  wire logic [7:0]   in_wr_data,
   input  wire logic         out_wr,
   input  wire logic [7:0]   out_wr_pin,
   input  wire logic [6:0]   out_wr_code,
   input  wire logic         lock_set,
   input  wire logic         unlock_req,
   input  wire logic [7:0]   unlock_key,
   input  wire logic [5:0]   rd_in_idx,
   input  wire logic [7:0]   rd_pin,
   input  wire logic [3:0]   comparator_source,
   input  wire logic         pwm_gen4_high,
   input  wire logic         pwm_gen4_low,
   input  wire logic         sequencer_out_30,
   input  wire logic         sequencer_out_31,
   input  wire logic         reference_clock_source,
   input  wire logic         pwm_sync_out_primary,
   input  wire logic         pwm_sync_out_secondary,
   input  wire logic [127:0] periph_out,
   input  wire logic [181:0] pin_in,
   input  wire logic [181:0] pin_analog_en,
   input  wire logic [181:0] port_out,
   input  wire logic [181:0] port_oe_n,
   output logic [36:0]       periph_in,
   output logic [181:0]      pin_out,
   output logic [181:0]      pin_oe_n,
   output logic [181:0]      pin_remap_active,
   output logic              map_locked,
   output logic [7:0]        rd_in_data,
   output logic [6:0]        rd_code
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam int NI = pin_crossbar_pkg::NUM_IN;
   localparam int NP = pin_crossbar_pkg::NUM_PIN;

   typedef struct packed {
      logic [NI-1:0][7:0] input_select_reg;
      logic [NP-1:0][6:0] output_select_reg;
      logic               locked;
      logic [NP-1:0]      sync1;
      logic [NP-1:0]      sync2;
      logic [NI-1:0]      periph_in;
      logic [NP-1:0]      pin_out;
      logic [NP-1:0]      pin_oe_n;
      logic [NP-1:0]      remap_active;
      logic [7:0]         rd_in;
      logic [6:0]         rd_code;
   } state_t;

   // Pins are released (not driven) during reset, then follow port_oe_n until mapped
   localparam state_t RESET_STATE = '{
      input_select_reg:  {NI{pin_crossbar_pkg::IN_SEL_RESET}},
      output_select_reg: {NP{pin_crossbar_pkg::OUT_SEL_RESET}},
      pin_oe_n:          '1,
      default:           '0
   };

   state_t                                 st;
   state_t                                 next_st;
   logic [pin_crossbar_pkg::NUM_INDEX-1:0] src;
   logic [NP-1:0]                          remap_val;
   logic [NP-1:0]                          remap_active;
   logic [NP-1:0]                          drv_out;
   logic [NP-1:0]                          drv_oe_n;

   // ------------------------------------------------------------
   // Per-pin output multiplexers
   // ------------------------------------------------------------
   generate
      for (genvar p = 0; p < NP; p++) begin : g_pin
         pin_output_stage #(
            .HAS_CELLS_34 (HAS_CELLS_34)
         ) u_stage (
            .code         (st.output_select_reg[p]),
            .periph_out   (periph_out),
            .analog_en    (pin_analog_en[p]),
            .port_out     (port_out[p]),
            .port_oe_n    (port_oe_n[p]),
            .remap_val    (remap_val[p]),
            .remap_active (remap_active[p]),
            .drv_out      (drv_out[p]),
            .drv_oe_n     (drv_oe_n[p])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      // Reserved indices stay at zero and read as ground
      src = '0;
      src[pin_crossbar_pkg::IDX_GROUND] = 1'b0;
      src[pin_crossbar_pkg::IDX_CMP_FIRST +: 4] = comparator_source;
      src[pin_crossbar_pkg::IDX_PWM_GEN4_HIGH] = pwm_gen4_high;
      src[pin_crossbar_pkg::IDX_SEQ30] = sequencer_out_30;
      src[pin_crossbar_pkg::IDX_SEQ31] = sequencer_out_31;
      src[pin_crossbar_pkg::IDX_REFERENCE_CLOCK_SOURCE]  = reference_clock_source;
      src[pin_crossbar_pkg::IDX_SYNC1] = pwm_sync_out_primary;
      src[pin_crossbar_pkg::IDX_SYNC2] = pwm_sync_out_secondary;
      src[pin_crossbar_pkg::IDX_PWM_GEN4_LOW] = pwm_gen4_low;
      for (int n = pin_crossbar_pkg::IDX_PIN_FIRST; n < NP; n++) begin
         if (pin_crossbar_pkg::is_rp(8'(n))) begin
            if (n >= pin_crossbar_pkg::IDX_VIRT_FIRST) begin
               // Virtual pins carry their own remapped output
               src[n] = remap_val[n];
            end else begin
               src[n] = st.sync2[n];
            end
         end
      end

      // Pins are asynchronous to clk_sys
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;

      // Locking wins over a same-cycle unlock attempt
      if (lock_set) begin
         next_st.locked = 1'b1;
      end else if (unlock_req && unlock_key == pin_crossbar_pkg::UNLOCK_KEY)
      begin
         next_st.locked = 1'b0;
      end

      // Any value is accepted; nothing cross-checks the fields
      if (!st.locked && in_wr && in_wr_idx < 6'(NI)) begin
         next_st.input_select_reg[in_wr_idx] = in_wr_data;
      end
      // Output codes sit in their own set, written independently
      if (!st.locked && out_wr && pin_crossbar_pkg::is_rp(out_wr_pin))
      begin
         next_st.output_select_reg[out_wr_pin] = out_wr_code;
      end

      // One mux per input function
      for (int i = 0; i < NI; i++) begin
         next_st.periph_in[i] = src[st.input_select_reg[i]];
      end

      next_st.pin_out      = drv_out;
      next_st.pin_oe_n     = drv_oe_n;
      next_st.remap_active = remap_active;

      next_st.rd_in = (rd_in_idx < 6'(NI)) ?
                      st.input_select_reg[rd_in_idx] : 8'h00;
      next_st.rd_code = pin_crossbar_pkg::is_rp(rd_pin) ?
                        st.output_select_reg[rd_pin] : 7'h00;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st <= RESET_STATE;
      end else begin
         st <= next_st;
      end
   end

   assign periph_in        = st.periph_in;
   assign pin_out          = st.pin_out;
   assign pin_oe_n         = st.pin_oe_n;
   assign pin_remap_active = st.remap_active;
   assign map_locked       = st.locked;
   assign rd_in_data       = st.rd_in;
   assign rd_code          = st.rd_code;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   logic [7:0] sel0;
   logic       sel0_phys;
   logic       sel0_pin;
   logic [6:0] code16;

   assign sel0      = st.input_select_reg[0];
   assign sel0_phys = pin_crossbar_pkg::is_rp(sel0) && sel0 < 8'hb0;
   assign sel0_pin  = sel0_phys ? st.sync2[sel0] : 1'b0;
   assign code16    = st.output_select_reg[16];

   a_pin_input_route: assert property (
      sel0_phys |=> st.periph_in[0] == $past(sel0_pin))
      else $error("periph input 0 does not follow its pin");

   a_reserved_low: assert property (
      (sel0 == 8'h00 || (sel0 >= 8'h08 && sel0 <= 8'h0b) ||
       (sel0 >= 8'h4d && sel0 <= 8'haf)) |=> !st.periph_in[0])
      else $error("ground or reserved index gave high input");

   a_comp_source: assert property (
      sel0 == 8'h01 && $stable(sel0) |=>
      st.periph_in[0] == $past(comparator_source[0]))
      else $error("comparator one not routed to input");

   a_virtual_loop: assert property (
      st.output_select_reg[176] == pin_crossbar_pkg::OUT_ANALOG_COMPARATOR_ONE_OUT &&
      st.input_select_reg[10] == 8'hb0
      |=> st.periph_in[10] == $past(periph_out[24]))
      else $error("virtual pin loopback broken");

   a_null_output: assert property (
      !pin_crossbar_pkg::code_ok(code16) |=>
      !st.remap_active[16] && st.pin_oe_n[16] == $past(port_oe_n[16]))
      else $error("null or reserved code drove pin");

   a_analog_wins: assert property (
      pin_analog_en[50] |=> !st.remap_active[50] &&
      st.pin_out[50] == $past(port_out[50]))
      else $error("remap overrode analog pin");

   a_remap_wins: assert property (
      pin_crossbar_pkg::code_ok(code16) && !pin_analog_en[16] |=>
      !st.pin_oe_n[16] && st.pin_out[16] == $past(periph_out[code16]))
      else $error("remap did not take the pin");

   a_lock_blocks: assert property (
      st.locked && !(unlock_req && unlock_key ==
      pin_crossbar_pkg::UNLOCK_KEY) ##1 st.locked
      |-> $stable(st.input_select_reg) && $stable(st.output_select_reg))
      else $error("mapping changed while locked");

   a_write_takes: assert property (
      !st.locked && in_wr && in_wr_idx < 6'(NI) |=>
      st.input_select_reg[$past(in_wr_idx)] == $past(in_wr_data))
      else $error("input selector write lost");

   a_maps_apart: assert property (
      out_wr && !in_wr |=> $stable(st.input_select_reg))
      else $error("output write touched input map");

   c_virtual_loop: cover property (
      st.output_select_reg[176] != 7'h00 && st.input_select_reg[10] == 8'hb0);
   c_lock_cycle: cover property (st.locked ##[1:20] !st.locked);
   c_pin_remapped: cover property (st.remap_active[16] ##1 st.pin_out[16]);

endmodule

// ### logic/pin_crossbar_pkg.sv
package pin_crossbar_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_IN    = 37;
   localparam int NUM_PIN   = 182;
   localparam int SEL_W     = 8;
   localparam int CODE_W    = 7;
   localparam int NUM_CODE  = 128;
   localparam int NUM_INDEX = 256;

   // ------------------------------------------------------------
   // Input selection indices for internal sources
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_GROUND     = 8'h00;
   localparam int         IDX_CMP_FIRST  = 1;
   localparam int         IDX_PWM_GEN4_HIGH      = 5;
   localparam int         IDX_SEQ30      = 6;
   localparam int         IDX_SEQ31      = 7;
   localparam int         IDX_REFERENCE_CLOCK_SOURCE       = 12;
   localparam int         IDX_SYNC1      = 13;
   localparam int         IDX_SYNC2      = 14;
   localparam int         IDX_PWM_GEN4_LOW      = 15;
   localparam int         IDX_PIN_FIRST  = 16;
   localparam int         IDX_VIRT_FIRST = 176;

   // ------------------------------------------------------------
   // Reset values and the unlock key
   // ------------------------------------------------------------
   localparam logic [7:0] IN_SEL_RESET  = 8'h00;
   localparam logic [6:0] OUT_SEL_RESET = 7'h00;
   // Arbitrary key value
   localparam logic [7:0] UNLOCK_KEY    = 8'h5a;

   // ------------------------------------------------------------
   // Remappable peripheral inputs, position in the periph_in vector
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      IN_EXT_EXTERNAL_INTERRUPT_ONE, IN_EXT_INT2, IN_TMR1_CLK, IN_TMR2_CLK, IN_TMR3_CLK,
      IN_CAP1, IN_CAP2, IN_CAP3, IN_CAP4, IN_CMP_FAULT_A,
      IN_PWM_PWM_FAULT_ONE, IN_PWM_FLT2, IN_PWM_FLT3, IN_PWM_FLT4,
      IN_UART1_RX, IN_UART1_CTS, IN_UART2_RX, IN_UART2_CTS,
      IN_SPI1_DIN, IN_SPI1_CLK, IN_SPI1_SEL, IN_CAN1_RX, IN_CAN2_RX,
      IN_SPI3_DIN, IN_SPI3_CLK, IN_SPI3_SEL,
      IN_SPI2_DIN, IN_SPI2_CLK, IN_SPI2_SEL,
      IN_PWM_SYNC1, IN_PWM_SYNC2,
      IN_PWM_FLT5, IN_PWM_FLT6, IN_PWM_FLT7, IN_PWM_FLT8,
      IN_CELL_A, IN_CELL_B
   } in_func_t;

   // ------------------------------------------------------------
   // Pin output codes, also the bit of periph_out that each drives
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      OUT_NULL = 7'h00,
      OUT_UART1_TX = 7'h01, OUT_UART1_RTS = 7'h02,
      OUT_UART2_TX = 7'h03, OUT_UART2_RTS = 7'h04,
      OUT_SPI1_DOUT = 7'h05, OUT_SPI1_CLK = 7'h06, OUT_SPI1_SEL = 7'h07,
      OUT_SPI2_DOUT = 7'h08, OUT_SPI2_CLK = 7'h09, OUT_SPI2_SEL = 7'h0a,
      OUT_CAN1_TX = 7'h0e, OUT_CAN2_TX = 7'h0f,
      OUT_CMPU1 = 7'h10, OUT_CMPU2 = 7'h11,
      OUT_CMPU3 = 7'h12, OUT_CMPU4 = 7'h13,
      OUT_ANALOG_COMPARATOR_ONE_OUT = 7'h18, OUT_ACMP2 = 7'h19, OUT_ACMP3 = 7'h1a,
      OUT_SPI3_DOUT = 7'h1f, OUT_SPI3_CLK = 7'h20, OUT_SPI3_SEL = 7'h21,
      OUT_SYNC_PRI = 7'h2d, OUT_SYNC_SEC = 7'h2e,
      OUT_REF_CLK = 7'h31,
      OUT_ACMP4 = 7'h32,
      OUT_PWM_GEN4_HIGH = 7'h33, OUT_PWM_GEN4_LOW = 7'h34,
      OUT_PWM5H = 7'h35, OUT_PWM5L = 7'h36,
      OUT_PWM6H = 7'h39, OUT_PWM6L = 7'h3a,
      OUT_PWM7H = 7'h3b, OUT_PWM7L = 7'h3c,
      OUT_PWM8H = 7'h3d, OUT_PWM8L = 7'h3e,
      OUT_CELL1 = 7'h3f, OUT_CELL2 = 7'h40,
      OUT_CELL3 = 7'h41, OUT_CELL4 = 7'h42
   } out_code_t;

   // Implemented remappable pin numbers, physical and virtual
   function automatic logic is_rp(input logic [7:0] n);
      return (n >= 8'h10 && n <= 8'h14) || (n >= 8'h20 && n <= 8'h29) ||
             (n >= 8'h2b && n <= 8'h3a) || (n >= 8'h3c && n <= 8'h4c) ||
             (n >= 8'hb0 && n <= 8'hb5);
   endfunction

   // Codes with a peripheral behind them; the null code is not one
   function automatic logic code_ok(input logic [6:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         OUT_UART1_TX, OUT_UART1_RTS, OUT_UART2_TX, OUT_UART2_RTS,
         OUT_SPI1_DOUT, OUT_SPI1_CLK, OUT_SPI1_SEL, OUT_SPI2_DOUT,
         OUT_SPI2_CLK, OUT_SPI2_SEL, OUT_CAN1_TX, OUT_CAN2_TX,
         OUT_CMPU1, OUT_CMPU2, OUT_CMPU3, OUT_CMPU4,
         OUT_ANALOG_COMPARATOR_ONE_OUT, OUT_ACMP2, OUT_ACMP3, OUT_ACMP4,
         OUT_SPI3_DOUT, OUT_SPI3_CLK, OUT_SPI3_SEL,
         OUT_SYNC_PRI, OUT_SYNC_SEC, OUT_REF_CLK,
         OUT_PWM_GEN4_HIGH, OUT_PWM_GEN4_LOW, OUT_PWM5H, OUT_PWM5L, OUT_PWM6H,
         OUT_PWM6L, OUT_PWM7H, OUT_PWM7L, OUT_PWM8H, OUT_PWM8L,
         OUT_CELL1, OUT_CELL2, OUT_CELL3, OUT_CELL4: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

endpackage

// ### logic/pin_output_stage.sv
`timescale 1ns/100ps

module pin_output_stage #(
   parameter bit HAS_CELLS_34 = 1'b1
) (
   input  wire logic [6:0]   code,
   input  wire logic [127:0] periph_out,
   input  wire logic         analog_en,
   input  wire logic         port_out,
   input  wire logic         port_oe_n,
   output logic              remap_val,
   output logic              remap_active,
   output logic              drv_out,
   output logic              drv_oe_n
);

   logic valid;

   always_comb begin
      // Reserved codes fall back to the null code
      valid = pin_crossbar_pkg::code_ok(code);
      if (!HAS_CELLS_34 && (code == pin_crossbar_pkg::OUT_CELL3 ||
                            code == pin_crossbar_pkg::OUT_CELL4)) begin
         valid = 1'b0;
      end
      // Code value selects the peripheral bit directly
      remap_val    = valid & periph_out[code];
      // Analog use of the pin keeps the remap off it
      remap_active = valid & ~analog_en;
      // Remap beats the port latch and any other digital function
      drv_out  = remap_active ? periph_out[code] : port_out;
      drv_oe_n = remap_active ? 1'b0 : port_oe_n;
   end

endmodule

// ### dv/far_side_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Peripherals and pads around the crossbar
// ------------------------------------------------------------
module far_side_model (
   input  wire logic         clk_sys,
   input  wire logic         refresh,
   output logic [3:0]        comparator_source,
   output logic [6:0]        misc_src,
   output logic [127:0]      periph_out,
   output logic [181:0]      pin_in
);
   logic [191:0] wide;
   logic         pend = 1'b0;

   // Values hold between refreshes so that every routed bit is predictable
   task automatic shuffle();
      wide = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      pin_in = wide[181:0];
      periph_out = {$urandom, $urandom, $urandom, $urandom};
      comparator_source = 4'($urandom);
      misc_src = 7'($urandom);
   endtask

   initial begin
      shuffle();
   end

   // New values land on the falling edge, clear of the sampling edge
   always @(posedge clk_sys) begin
      pend <= refresh;
   end

   always @(negedge clk_sys) begin
      if (pend) begin
         shuffle();
      end
   end
endmodule

// ### dv/remappable_pin_crossbar_tb.sv
`timescale 1ns/100ps

module remappable_pin_crossbar_tb;
   typedef struct {int due; int sel; int idx; logic [7:0] exp;} note_t;
   logic clk_sys = 1'b0, rstn = 1'b0, in_wr = 1'b0, out_wr = 1'b0;
   logic lock_set = 1'b0, unlock_req = 1'b0, refresh = 1'b0;
   logic [5:0]   in_wr_idx = 6'h00, rd_in_idx = 6'h00;
   logic [7:0]   in_wr_data = 8'h00, out_wr_pin = 8'h00;
   logic [7:0]   unlock_key = 8'h00, rd_pin = 8'h00, rd_in_data;
   logic [6:0]   out_wr_code = 7'h00, misc, rd_code;
   logic [3:0]   cmp;
   logic [127:0] periph_out;
   logic [181:0] pin_in, port_out, port_oe_n, pin_out, pin_oe_n;
   logic [181:0] pin_analog_en = '0, pin_remap_active;
   logic [191:0] wide;
   logic [36:0]  periph_in;
   logic         map_locked;
   note_t        notes[$], mon;
   int           cyc = 0, bad_count = 0, num_checks = 0, f, p, c;
   int idx_tab[] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11, 12, 13, 14, 15, 16, 20,
                     21, 31, 32, 41, 42, 43, 58, 59, 60, 76, 77, 175, 182,
                     255};

   remappable_pin_crossbar #(.HAS_CELLS_34(1'b1)) remappable_pin_crossbar_i (
      .clk_sys(clk_sys), .rstn(rstn), .in_wr(in_wr), .in_wr_idx(in_wr_idx),
      .in_wr_data(in_wr_data), .out_wr(out_wr), .out_wr_pin(out_wr_pin),
      .out_wr_code(out_wr_code), .lock_set(lock_set),
      .unlock_req(unlock_req), .unlock_key(unlock_key),
      .rd_in_idx(rd_in_idx), .rd_pin(rd_pin), .comparator_source(cmp),
      .pwm_gen4_high(misc[0]), .pwm_gen4_low(misc[1]),
      .sequencer_out_30(misc[2]), .sequencer_out_31(misc[3]),
      .reference_clock_source(misc[4]), .pwm_sync_out_primary(misc[5]),
      .pwm_sync_out_secondary(misc[6]), .periph_out(periph_out),
      .pin_in(pin_in), .pin_analog_en(pin_analog_en), .port_out(port_out),
      .port_oe_n(port_oe_n), .periph_in(periph_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_remap_active(pin_remap_active),
      .map_locked(map_locked), .rd_in_data(rd_in_data), .rd_code(rd_code));

   far_side_model far_side_model_i (
      .clk_sys(clk_sys), .refresh(refresh), .comparator_source(cmp),
      .misc_src(misc), .periph_out(periph_out), .pin_in(pin_in));

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc = cyc + 1;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] observe(input int sel, input int i);
      case (sel)
         0: return {7'h00, periph_in[i]};
         1: return {7'h00, pin_out[i]};
         2: return {7'h00, pin_oe_n[i]};
         3: return {7'h00, pin_remap_active[i]};
         4: return rd_in_data;
         5: return {1'b0, rd_code};
         default: return {7'h00, map_locked};
      endcase
   endfunction

   function automatic bit pin_idx(input int i);
      return (i >= 16 && i <= 20) || (i >= 32 && i <= 41) ||
             (i >= 43 && i <= 58) || (i >= 60 && i <= 76);
   endfunction

   function automatic bit has_src(input int k);
      return (k >= 1 && k <= 10) || (k >= 14 && k <= 19) ||
             (k >= 24 && k <= 26) || (k >= 31 && k <= 33) || k == 45 ||
             k == 46 || (k >= 49 && k <= 54) || (k >= 57 && k <= 66);
   endfunction

   function automatic logic exp_src(input int i);
      if (i >= 1 && i <= 4) return cmp[i-1];
      case (i)
         5: return misc[0];
         6: return misc[2];
         7: return misc[3];
         12: return misc[4];
         13: return misc[5];
         14: return misc[6];
         15: return misc[1];
         default: return pin_idx(i) ? pin_in[i] : 1'b0;
      endcase
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic note(input int sel, input int i, input logic [7:0] e,
                       input int lat);
      notes.push_back('{cyc + lat, sel, i, e});
   endtask

   task automatic wr_in(input int fn, input int v);
      in_wr = 1'b1;
      in_wr_idx = 6'(fn);
      in_wr_data = 8'(v);
      tick(1);
      in_wr = 1'b0;
      tick(1);
   endtask

   task automatic wr_out(input int pn, input int k);
      out_wr = 1'b1;
      out_wr_pin = 8'(pn);
      out_wr_code = 7'(k);
      tick(1);
      out_wr = 1'b0;
      tick(1);
   endtask

   task automatic stir();
      refresh = 1'b1;
      wide = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      port_out = wide[181:0];
      wide = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      port_oe_n = wide[181:0];
      tick(1);
      refresh = 1'b0;
      tick(1);
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Result watcher
   // ------------------------------------------------------------
   always @(negedge clk_sys) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         mon = notes.pop_front();
         check(observe(mon.sel, mon.idx), mon.exp);
      end
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      void'($urandom(33794));
      port_out = '0;
      port_oe_n = '1;
      tick(14);
      stir();
      rstn = 1'b1;
      for (int i = 0; i < 182; i++) begin
         note(1, i, {7'h00, port_out[i]}, 3);
         note(2, i, {7'h00, port_oe_n[i]}, 3);
         note(3, i, 8'h00, 3);
         if (i < 37) note(0, i, 8'h00, 3);
      end
      note(4, 0, 8'h00, 3);
      note(5, 0, 8'h00, 3);
      tick(4);
      $display("reset test done");
      foreach (idx_tab[k]) begin
         f = $urandom_range(36);
         wr_in(f, idx_tab[k]);
         rd_in_idx = 6'(f);
         stir();
         note(0, f, {7'h00, exp_src(idx_tab[k])}, 5);
         note(4, 0, 8'(idx_tab[k]), 5);
         tick(6);
      end
      $display("input select test done");
      for (c = 0; c < 128; c++) begin
         p = pin_idx(c + 16) ? c + 16 : 16;
         wr_out(p, c);
         rd_pin = 8'(p);
         stir();
         note(1, p, {7'h00, has_src(c) ? periph_out[c] : port_out[p]},
              5);
         note(2, p, {7'h00, has_src(c) ? 1'b0 : port_oe_n[p]},
              5);
         note(3, p, {7'h00, has_src(c)}, 5);
         note(5, 0, 8'(c), 5);
         tick(6);
         wr_out(p, 0);
      end
      wr_out(42, 1);
      rd_pin = 8'd42;
      note(5, 0, 8'h00, 5);
      tick(6);
      $display("output code test done");
      wr_out(176, 24);
      wr_out(181, 24);
      wr_in(10, 176);
      wr_in(11, 176);
      wr_in(12, 181);
      stir();
      for (int i = 10; i < 13; i++) begin
         note(0, i, {7'h00, periph_out[24]}, 5);
      end
      tick(6);
      wr_out(50, 1);
      pin_analog_en[50] = 1'b1;
      stir();
      note(1, 50, {7'h00, port_out[50]}, 5);
      note(2, 50, {7'h00, port_oe_n[50]}, 5);
      note(3, 50, 8'h00, 5);
      tick(6);
      pin_analog_en[50] = 1'b0;
      stir();
      note(1, 50, {7'h00, periph_out[1]}, 5);
      tick(6);
      $display("virtual and analog test done");
      wr_in(0, 1);
      wr_in(0, 16);
      lock_set = 1'b1;
      note(6, 0, 8'h01, 1);
      tick(1);
      lock_set = 1'b0;
      wr_in(0, 32);
      rd_in_idx = 6'd0;
      unlock_req = 1'b1;
      unlock_key = ~pin_crossbar_pkg::UNLOCK_KEY;
      tick(1);
      unlock_req = 1'b0;
      note(4, 0, 8'h10, 5);
      note(6, 0, 8'h01, 5);
      tick(6);
      unlock_req = 1'b1;
      unlock_key = pin_crossbar_pkg::UNLOCK_KEY;
      note(6, 0, 8'h00, 1);
      tick(1);
      unlock_req = 1'b0;
      tick(1);
      in_wr = 1'b1;
      in_wr_idx = 6'd36;
      in_wr_data = 8'd181;
      out_wr = 1'b1;
      out_wr_pin = 8'd60;
      out_wr_code = 7'h3f;
      rd_in_idx = 6'd36;
      rd_pin = 8'd60;
      note(4, 0, 8'd181, 2);
      note(5, 0, 8'h3f, 2);
      tick(1);
      in_wr = 1'b0;
      out_wr = 1'b0;
      tick(4);
      $display("lock test done");
      stop_test();
   end
endmodule
